// ===== hw/scw_pkg.sv
// Constants for the synthesizer channel word control block.
// Assumes an 8-bit register port and a synthesizer that takes a
// divide value in units of the reference divided by 65536.
package scw_pkg;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int WORD_W = 24;
	localparam int SYN_W = 27;
	// Register offsets
	localparam logic [6:0] OFS_W1_HIGH = 7'h00;
	localparam logic [6:0] OFS_W1_MID = 7'h01;
	localparam logic [6:0] OFS_W1_LOW = 7'h02;
	localparam logic [6:0] OFS_W2_HIGH = 7'h03;
	localparam logic [6:0] OFS_W2_MID = 7'h04;
	localparam logic [6:0] OFS_W2_LOW = 7'h05;
	localparam logic [6:0] OFS_MAIN = 7'h06;
	localparam logic [6:0] OFS_ANALOG = 7'h07;
	localparam logic [6:0] OFS_CLOCK = 7'h08;
	localparam logic [6:0] OFS_DEVIATION = 7'h09;
	localparam logic [6:0] OFS_MODEM = 7'h0a;
	localparam logic [6:0] OFS_FILTER = 7'h0b;
	localparam logic [6:0] OFS_STATUS = 7'h0c;
	// Field positions
	localparam int POS_PICK = 0;
	localparam int POS_BAND = 0;
	localparam int POS_REF_DIV = 0;
	localparam int POS_DEV_MANT = 0;
	localparam int POS_DEV_EXP = 4;
	localparam int POS_SHAPING = 7;
	localparam int POS_ADC_DIV = 0;
	localparam int POS_BYPASS = 0;
	// Reset values
	localparam logic [23:0] RST_WORD = 24'h000000;
	localparam logic [2:0] RST_REF_DIV = 3'h1;
	localparam logic [3:0] RST_DEV_MANT = 4'h0;
	localparam logic [2:0] RST_DEV_EXP = 3'h0;
	localparam logic [2:0] RST_ADC_DIV = 3'h0;
	// Synthesizer base divide values in units of fref/65536, IF divide unit, unmapped read value
	localparam logic [26:0] BASE_LOWER = 27'h000c000;
	localparam logic [26:0] BASE_UPPER = 27'h0018000;
	localparam logic [6:0] IF_DIV_UNIT = 7'h08;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;
endpackage

// ===== hw/scw_top.sv
// Channel word, band, deviation and IF divider control for a synthesizer.
// Registers over a plain strobe port; tx pins come from outside and are synchronised.
// Contract
// - Two channel words are stored; the word-pick bit selects which one drives the synthesizer.
// - Each word is three bytes high to low; low byte bit zero is spur_spread_enable enable.
// - Lower band output is reference times three quarters plus (word plus half spur_spread_enable)/32768.
// - Upper band output is reference times three halves plus (word plus half spur_spread_enable)/16384.
// - Band bit clear selects 402-470 MHz, set selects 804-960 MHz.
// - Reference is crystal divided by predivider field plus one; field is 0 to 7.
// - FSK sends carrier minus deviation for one symbol, plus deviation for other.
// - Deviation is reference times mantissa times two to exponent minus 16 or 15.
// - An all-zero mantissa selects on-off keying instead of FSK.
// - One shaping bit turns Gaussian filtering of the modulation on or off.
// - Receive IF is crystal divided by eight times sampler divider field plus one.
// - IF is a quarter of the sampler clock; software aims near 1.2288 MHz.
// - Bypass bit routes signal around the analog filter; software sets it when needed.
`timescale 1ns/1ps
module scw_top (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_reset_n,
	// Register port
	input wire logic [scw_pkg::ADDR_W-1:0] i_addr,
	input wire logic [scw_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_write,
	input wire logic i_read,
	output logic [scw_pkg::DATA_W-1:0] o_rdata,
	// Transmit pins
	input wire logic i_tx_enable,
	input wire logic i_tx_data,
	// Synthesizer control
	output logic [scw_pkg::SYN_W-1:0] o_synth_div,
	output logic o_band_range_bit,
	output logic o_spur_spread_enable,
	output logic [3:0] o_ref_div_ratio,
	// Modulation control
	output logic o_ook_mode,
	output logic o_carrier_on,
	output logic o_gauss_shaping,
	// Receive path control
	output logic [6:0] o_if_div_ratio,
	output logic o_filter_bypass
);
	import scw_pkg::*;

	typedef struct packed {
		logic [23:0] channel_word_one;
		logic [23:0] channel_word_two;
		logic pick;
		logic band;
		logic [2:0] ref_div;
		logic [3:0] deviation_mantissa;
		logic [2:0] deviation_exponent;
		logic shaping;
		logic [2:0] adc_div;
		logic bypass;
		logic en_meta;
		logic en_sync;
		logic data_meta;
		logic data_sync;
		logic [7:0] rdata;
		logic [26:0] synth_div;
		logic spread;
		logic [3:0] ref_ratio;
		logic ook;
		logic carrier_on;
		logic [6:0] if_ratio;
	} scw_state_s;

	scw_state_s state_r;
	scw_state_s state_nxt;

	logic [23:0] sel_word;
	logic [22:0] freq_val;
	logic spur_spread_enable;
	logic [26:0] base_div;
	logic [26:0] dev_div;
	logic [26:0] mod_div;
	logic ook_now;
	logic [7:0] status_val;

	always_comb begin
		state_nxt = state_r;
		// Word selection never writes either stored word
		sel_word = state_r.pick ? state_r.channel_word_two : state_r.channel_word_one;
		freq_val = sel_word[23:1];
		spur_spread_enable = sel_word[0];
		// Divide value in units of fref/65536
		if (!state_r.band) begin
			base_div = BASE_LOWER + {3'h0, freq_val, 1'b0} + {26'h0, spur_spread_enable};
			dev_div = {23'h0, state_r.deviation_mantissa} << state_r.deviation_exponent;
		end else begin
			base_div = BASE_UPPER + {2'h0, freq_val, 2'h0} + {25'h0, spur_spread_enable, 1'b0};
			dev_div = {22'h0, state_r.deviation_mantissa, 1'b0} << state_r.deviation_exponent;
		end
		ook_now = (state_r.deviation_mantissa == 4'h0);
		mod_div = base_div;
		if (state_r.en_sync && !ook_now) begin
			if (state_r.data_sync) begin
				mod_div = base_div + dev_div;
			end else begin
				mod_div = base_div - dev_div;
			end
		end
		state_nxt.synth_div = mod_div;
		state_nxt.spread = spur_spread_enable;
		state_nxt.ook = ook_now;
		if (ook_now) begin
			state_nxt.carrier_on = state_r.en_sync && state_r.data_sync;
		end else begin
			state_nxt.carrier_on = state_r.en_sync;
		end
		state_nxt.ref_ratio = {1'b0, state_r.ref_div} + 4'h1;
		state_nxt.if_ratio = IF_DIV_UNIT * ({4'h0, state_r.adc_div} + 7'h01);
		// Two-stage synchronisers for the tx pins
		state_nxt.en_meta = i_tx_enable;
		state_nxt.en_sync = state_r.en_meta;
		state_nxt.data_meta = i_tx_data;
		state_nxt.data_sync = state_r.data_meta;
		status_val = {4'h0, state_r.carrier_on, state_r.ook, state_r.band, state_r.pick};
		// Register writes
		if (i_write) begin
			if (i_addr == OFS_W1_HIGH) begin
				state_nxt.channel_word_one[23:16] = i_wdata;
			end else if (i_addr == OFS_W1_MID) begin
				state_nxt.channel_word_one[15:8] = i_wdata;
			end else if (i_addr == OFS_W1_LOW) begin
				state_nxt.channel_word_one[7:0] = i_wdata;
			end else if (i_addr == OFS_W2_HIGH) begin
				state_nxt.channel_word_two[23:16] = i_wdata;
			end else if (i_addr == OFS_W2_MID) begin
				state_nxt.channel_word_two[15:8] = i_wdata;
			end else if (i_addr == OFS_W2_LOW) begin
				state_nxt.channel_word_two[7:0] = i_wdata;
			end else if (i_addr == OFS_MAIN) begin
				state_nxt.pick = i_wdata[POS_PICK];
			end else if (i_addr == OFS_ANALOG) begin
				state_nxt.band = i_wdata[POS_BAND];
			end else if (i_addr == OFS_CLOCK) begin
				state_nxt.ref_div = i_wdata[POS_REF_DIV+:3];
			end else if (i_addr == OFS_DEVIATION) begin
				state_nxt.deviation_mantissa = i_wdata[POS_DEV_MANT+:4];
				state_nxt.deviation_exponent = i_wdata[POS_DEV_EXP+:3];
				state_nxt.shaping = i_wdata[POS_SHAPING];
			end else if (i_addr == OFS_MODEM) begin
				state_nxt.adc_div = i_wdata[POS_ADC_DIV+:3];
			end else if (i_addr == OFS_FILTER) begin
				state_nxt.bypass = i_wdata[POS_BYPASS];
			end
		end
		// Register reads, data valid in the next cycle only
		state_nxt.rdata = READ_UNMAPPED;
		if (i_read) begin
			if (i_addr == OFS_W1_HIGH) begin
				state_nxt.rdata = state_r.channel_word_one[23:16];
			end else if (i_addr == OFS_W1_MID) begin
				state_nxt.rdata = state_r.channel_word_one[15:8];
			end else if (i_addr == OFS_W1_LOW) begin
				state_nxt.rdata = state_r.channel_word_one[7:0];
			end else if (i_addr == OFS_W2_HIGH) begin
				state_nxt.rdata = state_r.channel_word_two[23:16];
			end else if (i_addr == OFS_W2_MID) begin
				state_nxt.rdata = state_r.channel_word_two[15:8];
			end else if (i_addr == OFS_W2_LOW) begin
				state_nxt.rdata = state_r.channel_word_two[7:0];
			end else if (i_addr == OFS_MAIN) begin
				state_nxt.rdata = {7'h00, state_r.pick};
			end else if (i_addr == OFS_ANALOG) begin
				state_nxt.rdata = {7'h00, state_r.band};
			end else if (i_addr == OFS_CLOCK) begin
				state_nxt.rdata = {5'h00, state_r.ref_div};
			end else if (i_addr == OFS_DEVIATION) begin
				state_nxt.rdata = {state_r.shaping, state_r.deviation_exponent,
					state_r.deviation_mantissa};
			end else if (i_addr == OFS_MODEM) begin
				state_nxt.rdata = {5'h00, state_r.adc_div};
			end else if (i_addr == OFS_FILTER) begin
				state_nxt.rdata = {7'h00, state_r.bypass};
			end else if (i_addr == OFS_STATUS) begin
				state_nxt.rdata = status_val;
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			state_r <= '0;
			state_r.channel_word_one <= RST_WORD;
			state_r.channel_word_two <= RST_WORD;
			state_r.ref_div <= RST_REF_DIV;
			state_r.deviation_mantissa <= RST_DEV_MANT;
			state_r.deviation_exponent <= RST_DEV_EXP;
			state_r.adc_div <= RST_ADC_DIV;
			state_r.synth_div <= BASE_LOWER;
			state_r.ref_ratio <= 4'h2;
			state_r.ook <= 1'b1;
			state_r.if_ratio <= IF_DIV_UNIT;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign o_rdata = state_r.rdata;
	assign o_synth_div = state_r.synth_div;
	assign o_band_range_bit = state_r.band;
	assign o_spur_spread_enable = state_r.spread;
	assign o_ref_div_ratio = state_r.ref_ratio;
	assign o_ook_mode = state_r.ook;
	assign o_carrier_on = state_r.carrier_on;
	assign o_gauss_shaping = state_r.shaping;
	assign o_if_div_ratio = state_r.if_ratio;
	assign o_filter_bypass = state_r.bypass;
endmodule

// ===== sim/scw_sva.sv
// Checker for the channel word control block.
// Sees only the top module ports and is bound to every scw_top.
`timescale 1ns/1ps
module scw_sva import scw_pkg::*; (
	input wire logic i_clock, i_reset_n, i_write, i_read, i_tx_enable,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata, o_rdata,
	input wire logic [3:0] o_ref_div_ratio,
	input wire logic [6:0] o_if_div_ratio,
	input wire logic o_filter_bypass, o_band_range_bit, o_ook_mode, o_gauss_shaping, o_carrier_on
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);
	a_rdata_slot: assert property (o_rdata != 8'h00 |-> $past(i_read))
		else $error("read data outside its slot");
	a_ref_ratio: assert property (i_write && i_addr == OFS_CLOCK |-> ##2
		o_ref_div_ratio == {1'b0, $past(i_wdata[2:0], 2)} + 4'h1) else $error("ref ratio wrong");
	a_if_ratio: assert property (i_write && i_addr == OFS_MODEM |-> ##2
		o_if_div_ratio == {1'b0, $past(i_wdata[2:0], 2), 3'h0} + 7'h08) else $error("if ratio wrong");
	a_band_bit: assert property (i_write && i_addr == OFS_ANALOG |-> ##2
		o_band_range_bit == $past(i_wdata[0], 2)) else $error("band bit wrong");
	a_filter_bypass: assert property (i_write && i_addr == OFS_FILTER |-> ##2
		o_filter_bypass == $past(i_wdata[0], 2)) else $error("bypass wrong");
	a_ook_select: assert property (i_write && i_addr == OFS_DEVIATION |-> ##2
		o_ook_mode == ($past(i_wdata[3:0], 2) == 4'h0)) else $error("ook mode wrong");
	a_gauss_bit: assert property (i_write && i_addr == OFS_DEVIATION |-> ##2
		o_gauss_shaping == $past(i_wdata[7], 2)) else $error("shaping wrong");
	a_carrier_off: assert property (!i_tx_enable [*3] |=> !o_carrier_on)
		else $error("carrier on while idle");
	c_pick: cover property (i_write && i_addr == OFS_MAIN && i_wdata[0]);
	c_ook_on: cover property (o_ook_mode && o_carrier_on);
	c_fsk_upper: cover property (o_band_range_bit && !o_ook_mode && o_carrier_on);
endmodule
bind scw_top scw_sva chk_i (.*);

// ===== sim/testbench.sv
// Self-checking bench for the channel word control block.
// Drives the register port and tx pins; expected results queue for a monitor.
`timescale 1ns/1ps
module testbench;
	import scw_pkg::*;
	logic i_clock = 1'b0, i_reset_n = 1'b0, i_write = 1'b0, i_read = 1'b0;
	logic i_tx_enable = 1'b0, i_tx_data = 1'b0, rd_seen = 1'b0, syn_req = 1'b0;
	logic [6:0] i_addr = 7'h00, o_if_div_ratio;
	logic [7:0] i_wdata = 8'h00, o_rdata;
	logic [26:0] o_synth_div;
	logic [3:0] o_ref_div_ratio;
	logic o_band_range_bit, o_spur_spread_enable, o_ook_mode, o_carrier_on;
	logic o_gauss_shaping, o_filter_bypass;
	logic [27:0] exp_q[$];
	int n_errors = 0, checks = 0;
	scw_top dut (.*);
	always #50 i_clock = ~i_clock;
	task chk(string name, logic [27:0] seen, logic [27:0] want);
		checks++;
		if (seen !== want) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", name, want, seen);
		end
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task wr(logic [6:0] a, logic [7:0] d);
		@(posedge i_clock);
		i_write <= 1'b1; i_addr <= a; i_wdata <= d;
		@(posedge i_clock);
		i_write <= 1'b0;
	endtask
	task rd(logic [6:0] a, logic [7:0] e);
		exp_q.push_back({20'h0, e});
		@(posedge i_clock);
		i_read <= 1'b1; i_addr <= a;
		@(posedge i_clock);
		i_read <= 1'b0;
	endtask
	task syn(logic [27:0] e);
		exp_q.push_back(e);
		@(posedge i_clock);
		syn_req <= 1'b1;
		@(posedge i_clock);
		syn_req <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	always @(posedge i_clock) rd_seen <= i_read;
	always @(negedge i_clock) if (rd_seen || syn_req)
		chk(rd_seen ? "rdata" : "synth", rd_seen ? {20'h0, o_rdata} : {o_spur_spread_enable, o_synth_div}, exp_q.pop_front());
	initial begin
		repeat (20000) @(posedge i_clock);
		n_errors++;
		end_sim;
	end
	initial begin
		logic [23:0] w1, w2, w;
		logic [26:0] base, dev;
		logic [7:0] dv, rv, av, fv;
		logic [3:0] m;
		logic band, pick, en;
		void'($urandom(32'head2));
		repeat (3) @(posedge i_clock);
		i_reset_n <= 1'b1;
		@(negedge i_clock);
		chk("ref ratio", 28'(o_ref_div_ratio), 28'h2);
		chk("if ratio", 28'(o_if_div_ratio), 28'h8);
		syn({1'b0, 27'h000c000});
		rd(OFS_STATUS, 8'h04);
		rd(7'h40, 8'h00);
		$display("reset test done");
		for (int i = 0; i < 8; i++) begin
			w1 = 24'($urandom); w2 = 24'($urandom); dv = 8'($urandom);
			m = (i == 5) ? 4'h0 : dv[3:0];
			dv[3:0] = m; band = i[0]; pick = 1'($urandom); en = (i != 6);
			// Words are arbitrary LO or carrier values, spur_spread_enable bit random
			for (int k = 0; k < 6; k++) wr(7'(k), k < 3 ? w1[23-8*k -: 8] : w2[47-8*k -: 8]);
			wr(OFS_ANALOG, {7'h0, band}); wr(OFS_DEVIATION, dv); wr(OFS_MAIN, {7'h0, pick});
			rv = 8'($urandom); av = 8'($urandom); fv = 8'($urandom);
			wr(OFS_CLOCK, rv);
			wr(OFS_MODEM, av); wr(OFS_FILTER, fv);
			w = pick ? w2 : w1;
			base = band ? 27'd98304 + 27'(w[23:1]) * 4 + 27'(w[0]) * 2 : 27'd49152 + 27'(w[23:1]) * 2 + 27'(w[0]);
			dev = (27'(m) << dv[6:4]) << band;
			for (int d = 0; d < 2; d++) begin
				i_tx_enable <= en; i_tx_data <= d[0];
				repeat (4) @(posedge i_clock);
				syn({w[0], (en && m != 0) ? (d[0] ? base + dev : base - dev) : base});
				rd(OFS_STATUS, {4'h0, en && (m != 0 || d[0]), m == 4'h0, band, pick});
			end
			@(negedge i_clock);
			chk("band", 28'(o_band_range_bit), 28'(band));
			chk("ook", 28'(o_ook_mode), 28'(m == 4'h0));
			chk("shaping", 28'(o_gauss_shaping), 28'(dv[7]));
			chk("ref ratio", 28'(o_ref_div_ratio), 28'(rv[2:0]) + 28'h1);
			chk("if ratio", 28'(o_if_div_ratio), 28'h8 * (28'(av[2:0]) + 28'h1));
			chk("bypass", 28'(o_filter_bypass), 28'(fv[0]));
			rd(pick ? OFS_W1_LOW : OFS_W2_LOW, pick ? w1[7:0] : w2[7:0]);
			$display("test %0d done", i);
		end
		end_sim;
	end
endmodule
